//--- rtl/ttu_pkg.sv
// Overview of operation
// R1: Three independent timers advance on a tick that comes every fourth processor clock.
// R2: While power save is asserted the tick rate drops further, as the slowed system clock would.
// R3: Each timer has its own control word, written by software, that selects its behaviour.
// R4: The first two timers hold two separately loaded compare values, A and B.
// R5: In dual compare mode the output is high while counting to A, then low while counting to B.
// R6: The prescale timer's terminal count can be chosen as the count source of either other timer.
// R7: The prescale timer acts like the others but has only compare value A and no output pin.
// R8: On reaching full count with interrupt enable set, a timer raises its interrupt request.
// R9: Each control word carries a full count flag that software can poll.
// R10: Every count value is readable at any time without disturbing the counting.
// R11: On the tick after the count reaches the active compare value it returns to zero, and goes on unless a one-shot timer has finished.
// R12: The full count flag stays set until software writes the control word.
package ttu_pkg;
   localparam int         TIMERS    = 3;
   localparam int         COUNT_W   = 16;
   localparam int         BASE_DIV  = 4;
   localparam int         PS_DIV    = 8;
   // ------------------------------------------------------------
   // Control word fields
   // ------------------------------------------------------------
   localparam int         CTL_EN    = 0;
   localparam int         CTL_IE    = 1;
   localparam int         CTL_CONT  = 2;
   localparam int         CTL_DUAL  = 3;
   localparam int         CTL_PRE   = 4;
   localparam int         CTL_FLAG  = 5;
   localparam int         CTL_W     = 6;
   localparam logic [4:0] CTL_RESET = 5'h00;
endpackage

//--- rtl/ttu_chan_if.sv
interface ttu_chan_if #(parameter int W = 16);
   logic         tick;
   logic         enable;
   logic         ie;
   logic         cont;
   logic         dual;
   logic         ctl_wr;
   logic [W-1:0] cmp_a;
   logic [W-1:0] cmp_b;
   logic [W-1:0] count;
   logic         out;
   logic         flag;
   logic         irq;
   logic         done;
   modport ctrl (output tick, enable, ie, cont, dual, ctl_wr, cmp_a, cmp_b,
                 input  count, out, flag, irq, done);
   modport chan (input  tick, enable, ie, cont, dual, ctl_wr, cmp_a, cmp_b,
                 output count, out, flag, irq, done);
endinterface

//--- rtl/ttu_chan.sv
module ttu_chan #(
   parameter bit HAS_B = 1'b1,
   parameter int W     = 16
) (
   input wire logic clk,
   input wire logic reset,
   ttu_chan_if.chan c
);
   logic         phase_b;
   logic         halted;
   logic         dual_eff;
   logic [W-1:0] max_now;
   logic         at_max;
   logic         step;
   logic         next_phase;

   assign dual_eff   = HAS_B && c.dual;                      // R7
   assign max_now    = (dual_eff && phase_b) ? c.cmp_b : c.cmp_a; // R4
   assign at_max     = (c.count == max_now);
   assign step       = c.tick && c.enable && !halted;
   assign next_phase = (step && at_max && dual_eff) ? !phase_b : (dual_eff && phase_b);

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         c.count <= '0;
      end else if (step) begin
         c.count <= at_max ? '0 : c.count + 1'b1;              // R11 R10
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase_b <= 1'b0;
         c.out   <= 1'b1;
      end else begin
         phase_b <= next_phase;
         c.out   <= !next_phase;                              // R5
      end
   end

   // One-shot mode stops after its last compare; a control write rearms it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         halted <= 1'b0;
      end else if (step && at_max && !c.cont && (!dual_eff || phase_b)) begin
         halted <= 1'b1;
      end else if (c.ctl_wr) begin
         halted <= 1'b0;
      end
   end

   // Set beats a clear in the same cycle so no terminal count is lost
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         c.flag <= 1'b0;
         c.irq  <= 1'b0;
         c.done <= 1'b0;
      end else begin
         c.done <= step && at_max;
         if (step && at_max) begin
            c.flag <= 1'b1;                                   // R9
         end else if (c.ctl_wr) begin
            c.flag <= 1'b0;                                   // R12
         end
         c.irq <= c.ie && ((step && at_max) || (c.flag && !c.ctl_wr)); // R8
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_hit;
      step && at_max;
   endsequence

   a_wrap_zero: assert property (s_hit |=> c.count == '0) // R11
      else $error("count did not return to zero at compare");
   a_count_hold: assert property (!step |=> c.count == $past(c.count)) // R10
      else $error("count moved without a tick");
   a_flag_set: assert property (s_hit |=> c.flag && c.done) // R9
      else $error("full count flag not set");
   a_flag_keep: assert property (c.flag && !c.ctl_wr |=> c.flag) // R12
      else $error("flag dropped without a control write");
   a_irq_follow: assert property ((s_hit and c.ie) |=> c.irq) // R8
      else $error("interrupt not raised at full count");
   a_dual_low: assert property ((s_hit and (dual_eff && !phase_b)) |=> !c.out ##0 phase_b) // R5
      else $error("output not low after compare a");
   // Phase settles one cycle after dual mode is switched off by a control write
   a_single_only: assert property (!dual_eff |=> c.out && !phase_b) // R7
      else $error("single compare timer left phase a");
endmodule

//--- rtl/ttu_top.sv
module ttu_top #(
   parameter int W      = ttu_pkg::COUNT_W,
   parameter int PS_DIV = ttu_pkg::PS_DIV
) (
   input  wire logic                                   clk,
   input  wire logic                                   reset,
   input  wire logic                                   power_save,
   input  wire logic [ttu_pkg::TIMERS-1:0]             ctl_wr,
   input  wire logic [4:0]                             ctl_wdata,
   input  wire logic [ttu_pkg::TIMERS-1:0][W-1:0]      compare_value_a,
   input  wire logic [1:0][W-1:0]                      compare_value_b,
   output logic      [ttu_pkg::TIMERS-1:0][W-1:0]      count,
   output logic      [ttu_pkg::TIMERS-1:0][ttu_pkg::CTL_W-1:0] ctl_read,
   output logic      [ttu_pkg::TIMERS-1:0]             full_count_flag,
   output logic      [ttu_pkg::TIMERS-1:0]             irq,
   output logic      [1:0]                             timer_out
);
   localparam int         NT      = ttu_pkg::TIMERS;
   localparam int         DIV_W   = $clog2(ttu_pkg::BASE_DIV);
   localparam int         PSW     = $clog2(PS_DIV);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ttu_pkg::BASE_DIV - 1);
   localparam logic [PSW-1:0]   PS_LAST  = PSW'(PS_DIV - 1);

   logic                  ps_meta;
   logic                  ps_sync;
   logic [DIV_W-1:0]      div_cnt;
   logic [PSW-1:0]        ps_cnt;
   logic                  base_tick;
   logic                  slow_tick;
   logic [NT-1:0][4:0]    ctl;

   ttu_chan_if #(.W(W)) ch [NT] ();

   // ------------------------------------------------------------
   // Power save pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ps_meta <= 1'b0;
         ps_sync <= 1'b0;
      end else begin
         ps_meta <= power_save;
         ps_sync <= ps_meta;
      end
   end

   // ------------------------------------------------------------
   // Count tick: quarter clock, slowed again in power save
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_cnt   <= '0;
         base_tick <= 1'b0;
      end else begin
         div_cnt   <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
         base_tick <= (div_cnt == DIV_LAST);                  // R1
      end
   end

   // The slowed rate is a fixed ratio; real clock scaling is outside this block
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ps_cnt <= '0;
      end else if (!ps_sync) begin
         ps_cnt <= '0;
      end else if (base_tick) begin
         ps_cnt <= (ps_cnt == PS_LAST) ? '0 : ps_cnt + 1'b1;  // R2
      end
   end

   assign slow_tick = base_tick && (!ps_sync || ps_cnt == PS_LAST); // R2

   // ------------------------------------------------------------
   // Control words
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl <= {NT{ttu_pkg::CTL_RESET}};
      end else begin
         for (int i = 0; i < NT; i++) begin
            if (ctl_wr[i]) begin
               ctl[i] <= ctl_wdata;                           // R3
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Timer channels
   // ------------------------------------------------------------
   for (genvar i = 0; i < NT; i++) begin : g_tmr
      localparam bit HB = (i < 2);
      assign ch[i].enable = ctl[i][ttu_pkg::CTL_EN];
      assign ch[i].ie     = ctl[i][ttu_pkg::CTL_IE];
      assign ch[i].cont   = ctl[i][ttu_pkg::CTL_CONT];
      assign ch[i].dual   = ctl[i][ttu_pkg::CTL_DUAL];
      assign ch[i].ctl_wr = ctl_wr[i];
      assign ch[i].cmp_a  = compare_value_a[i];
      if (HB) begin : g_ab
         assign ch[i].cmp_b = compare_value_b[i];            // R4
         // Chaining through the prescale timer widens the range past one count
         assign ch[i].tick  = ctl[i][ttu_pkg::CTL_PRE] ? ch[NT-1].done : slow_tick; // R6
         assign timer_out[i] = ch[i].out;
      end else begin : g_a
         assign ch[i].cmp_b = '0;                            // R7
         assign ch[i].tick  = slow_tick;
      end
      assign count[i]           = ch[i].count;               // R10
      assign full_count_flag[i] = ch[i].flag;
      assign irq[i]             = ch[i].irq;
      assign ctl_read[i]        = {ch[i].flag, ctl[i]};      // R9

      ttu_chan #(
         .HAS_B (HB),
         .W     (W)
      ) u_chan (
         .clk   (clk),
         .reset (reset),
         .c     (ch[i])
      );
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_quiet3;
      !base_tick [*3];
   endsequence

   a_tick_quarter: assert property (base_tick |=> s_quiet3 ##1 base_tick) // R1
      else $error("base tick not every fourth clock");
   // Leaving power save restarts the fast tick at once, so that cycle is exempt
   a_ps_slow: assert property (ps_sync && slow_tick |=> (!slow_tick || !ps_sync) [*7]) // R2
      else $error("power save did not slow the tick");
   a_ps_full: assert property (!ps_sync |-> slow_tick == base_tick) // R2
      else $error("tick slowed outside power save");
   a_ctl_load: assert property (ctl_wr[0] |=> ctl_read[0][4:0] == $past(ctl_wdata)) // R3
      else $error("control word not stored");
   a_pre_src: assert property (ctl[0][ttu_pkg::CTL_PRE] |-> ch[0].tick == ch[2].done) // R6
      else $error("prescale source not routed");
   a_flag_read: assert property (ctl_read[1][ttu_pkg::CTL_FLAG] == full_count_flag[1]) // R9
      else $error("flag missing from control readback");
endmodule

//--- tb/ttu_tb_top.sv
module ttu_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // Stimulus and observed ports
   // ------------------------------------------------------------
   logic                   clk = 1'b0;
   logic                   reset = 1'b1;
   logic                   power_save = 1'b0;
   logic [2:0]             ctl_wr = 3'h0;
   logic [4:0]             ctl_wdata = 5'h00;
   logic [2:0][15:0]       cmp_a = '0;
   logic [1:0][15:0]       cmp_b = '0;
   logic [2:0][15:0]       count;
   logic [2:0][5:0]        ctl_read;
   logic [2:0]             full_count_flag;
   logic [2:0]             irq;
   logic [1:0]             timer_out;
   int                     error_cnt = 0;
   int                     n_compared = 0;
   always #5 clk = ~clk;
   // Small slowdown keeps the power save run short
   ttu_top #(.W(16), .PS_DIV(2)) i_ttu_top (
      .clk             (clk),
      .reset           (reset),
      .power_save      (power_save),
      .ctl_wr          (ctl_wr),
      .ctl_wdata       (ctl_wdata),
      .compare_value_a (cmp_a),
      .compare_value_b (cmp_b),
      .count           (count),
      .ctl_read        (ctl_read),
      .full_count_flag (full_count_flag),
      .irq             (irq),
      .timer_out       (timer_out));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic ctl_write(input int i, input logic [4:0] d);
      @(negedge clk);
      ctl_wr[i] = 1'b1;
      ctl_wdata = d;
      @(negedge clk);
      ctl_wr = 3'h0;
      chk(16'(ctl_read[i][4:0]), 16'(d), "control readback");
   endtask
   // Counts advanced over a window; ticks are periodic so phase does not matter
   task automatic rate(input int i, input int cyc, input logic [15:0] exp);
      logic [15:0] c0;
      c0 = count[i];
      repeat (cyc) @(negedge clk);
      chk(count[i] - c0, exp, "count advance");
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 3; i++) begin
         chk(count[i], 16'h0000, "count after reset");
      end
      chk(16'({full_count_flag, irq, timer_out}), 16'h0003, "status after reset");
   endtask
   task automatic t_one_shot();
      int n;
      cmp_a[0] = 16'h0003;
      ctl_write(0, 5'h03);
      n = 0;
      while (full_count_flag[0] !== 1'b1) begin
         @(negedge clk);
         if (++n > 100) begin
            chk(16'h0000, 16'h0001, "flag timeout");
            print_verdict();
         end
      end
      // Compare A of three needs four ticks; rounding up absorbs the tick phase
      chk(16'((n + 3) / 4), 16'h0004, "ticks to full count");
      repeat (20) @(negedge clk);
      chk(16'({full_count_flag[0], irq[0], ctl_read[0][5]}), 16'h0007, "flag sticky");
      ctl_write(0, 5'h00);
      chk(16'({full_count_flag[0], irq[0]}), 16'h0000, "flag cleared");
   endtask
   task automatic t_wrap();
      logic [15:0] mx;
      mx = 0;
      ctl_write(0, 5'h05);
      repeat (60) begin
         @(negedge clk);
         if (count[0] > mx) mx = count[0];
      end
      chk(mx, 16'h0003, "highest count");
      chk(16'(irq[0]), 16'h0000, "irq with ie clear");
   endtask
   task automatic t_rate();
      cmp_a[0] = 16'hffff;
      ctl_write(0, 5'h05);
      rate(0, 40, 16'd10);
      chk(16'(timer_out[0]), 16'h0001, "out high when single");
      power_save = 1'b1;
      repeat (20) @(negedge clk);
      rate(0, 80, 16'd10);
      power_save = 1'b0;
      repeat (20) @(negedge clk);
   endtask
   task automatic t_dual();
      int lows;
      lows = 0;
      cmp_a[1] = 16'h0002;
      cmp_b[1] = 16'h0003;
      ctl_write(1, 5'h0d);
      repeat (30) @(negedge clk);
      // Phase A spans three ticks, phase B four
      repeat (56) begin
         @(negedge clk);
         if (timer_out[1] === 1'b0) lows++;
      end
      chk(16'(lows), 16'd32, "low cycles in two periods");
   endtask
   task automatic t_prescale();
      cmp_a[2] = 16'h0001;
      ctl_write(2, 5'h15);
      ctl_write(0, 5'h15);
      repeat (20) @(negedge clk);
      rate(0, 80, 16'd10);
      chk(16'({full_count_flag[2], irq[2]}), 16'h0002, "prescale timer flag");
   endtask
   initial begin
      repeat (4) @(negedge clk);
      reset = 1'b0;
      t_reset();
      t_one_shot();
      t_wrap();
      t_rate();
      t_dual();
      t_prescale();
      print_verdict();
   end
endmodule
